// ---- logic/ssf_params.svh ----
`ifndef SSF_PARAMS_SVH
`define SSF_PARAMS_SVH
// ----------------------------------------------------------------
// terminal function codes
// ----------------------------------------------------------------
`define SSF_FN_RATIO1   8'h1B
`define SSF_FN_RATIO2   8'h1C
`define SSF_FN_TEACH    8'h23
`define SSF_FN_CM_SEL   8'h24
`define SSF_FN_POS_CTL  8'h25
`define SSF_FN_TRQ_CTL  8'h26
`define SSF_FN_OVR_EN   8'h2B
`define SSF_FN_OVR_1    8'h2C
`define SSF_FN_OVR_2    8'h2D
`define SSF_FN_OVR_4    8'h2E
`define SSF_FN_OVR_8    8'h2F
// ----------------------------------------------------------------
// parameter values and motion figures
// ----------------------------------------------------------------
`define SSF_OPM_EXT     4'h6
`define SSF_OPM_POSN    4'h7
`define SSF_CMP_PS      4'h3
`define SSF_CMP_PT      4'h4
`define SSF_CMP_ST      4'h5
`define SSF_CMP_SPD     4'h1
`define SSF_CMP_TRQ     4'h2
`define SSF_CNT_PER_PLS 20'h00010
`define SSF_PCT_UNITY   8'h64
`define SSF_PCT_LIMIT   10'h096
// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define SSF_REG_CTRL    8'h00
`define SSF_REG_FUNC_LO 8'h04
`define SSF_REG_FUNC_HI 8'h08
`define SSF_REG_OVR_WGT 8'h0C
`define SSF_REG_SPEED   8'h10
`define SSF_REG_MAXSPD  8'h14
`define SSF_REG_STATUS  8'h18
`define SSF_REG_CMDPOS  8'h1C
`define SSF_REG_SCALED  8'h20
`define SSF_REG_ENTRY   8'h40
`define SSF_RST_CTRL    32'h0000_0000
`define SSF_RST_FUNC    32'h0000_0000
`define SSF_RST_OVR_WGT 32'h5028_140A
`define SSF_RST_SPEED   32'h0000_0000
`define SSF_RST_MAXSPD  32'h0000_FFFF
`endif

// ---- logic/ssf_pkg.sv ----
package ssf_pkg;
  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ssf_cm_pos, ssf_cm_spd, ssf_cm_trq} ssf_cmode_t;
  typedef enum logic {ssf_teach_idle, ssf_teach_done} ssf_teach_t;
  typedef logic [7:0] ssf_pct_t;
endpackage : ssf_pkg

// ---- logic/ssf_ovr_if.sv ----
interface ssf_ovr_if #(parameter int SPD_W = 16);
  import ssf_pkg::*;
  logic             enable;
  logic [3:0]       bits;
  ssf_pct_t         weight [4];
  logic [SPD_W-1:0] base;
  logic [SPD_W-1:0] max_spd;
  ssf_pct_t         mult;
  logic [SPD_W-1:0] scaled;
  modport ctl (output enable, bits, weight, base, max_spd,
               input mult, scaled);
  modport ovr (input enable, bits, weight, base, max_spd,
               output mult, scaled);
endinterface : ssf_ovr_if

// ---- logic/ssf_override.sv ----
`include "ssf_params.svh"
module ssf_override
  import ssf_pkg::*;
#(
  parameter int SPD_W = 16
)(
  input  wire logic hclk,
  input  wire logic hresetn,
  ssf_ovr_if.ovr    ov
);
  // ----------------------------------------------------------------
  // weighted sum of active override bits
  // ----------------------------------------------------------------
  logic [9:0]         sum;
  logic [SPD_W+7:0]   prod;
  logic [SPD_W+7:0]   quot;
  ssf_pct_t           mult_q;
  logic [SPD_W-1:0]   scaled_q;

  // each bit adds its own programmable weight
  always_comb
  begin
    sum = 10'h000;
    for (int i = 0; i < 4; i++)
      if (ov.bits[i])
        sum = sum + {2'b00, ov.weight[i]};
  end

  // ----------------------------------------------------------------
  // applied multiplier
  // ----------------------------------------------------------------
  // out-of-range sums keep the last good value so speed never jumps
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mult_q <= `SSF_PCT_UNITY;
    else if (!ov.enable)
      mult_q <= `SSF_PCT_UNITY;
    else if (sum <= `SSF_PCT_LIMIT)
      mult_q <= sum[7:0];
  end                   // sum above the limit holds mult_q

  // ----------------------------------------------------------------
  // scaled speed, clamped to the maximum
  // ----------------------------------------------------------------
  assign prod = {8'h00, ov.base} * {{SPD_W{1'b0}}, mult_q};
  assign quot = prod / {{SPD_W{1'b0}}, `SSF_PCT_UNITY};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      scaled_q <= '0;
    else if (quot > {8'h00, ov.max_spd})
      scaled_q <= ov.max_spd;
    else
      scaled_q <= quot[SPD_W-1:0];
  end

  assign ov.mult   = mult_q;
  assign ov.scaled = scaled_q;
endmodule : ssf_override

// ---- logic/ssf_seq_inputs.sv ----
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`include "ssf_params.svh"
// Behaviour
// - code 35 on a terminal binds teaching to it.
// - teaching acts only when operating mode is 7.
// - teach rising edge stores commanded position in addressed entry.
// - every taught position is marked absolute.
// - teaching ignores forced-stop and servo-on.
// - overwrite-done rises after store, drops when teach input low.
// - code 36 binds control-mode selection.
// - 3 pos/speed, 4 pos/torque, 5 speed/torque, low then high.
// - code 37 binds position control, 27 and 28 pulse ratios.
// - operating mode 6 holds position control while input high.
// - pulses accepted only with position control and a ratio high.
// - each accepted pulse moves 16 encoder counts.
// - position is 20 bits, 1048576 counts per revolution.
// - mode 6 holds torque control while code 38 input high.
// - torque only with forward or reverse run, which sets direction.
// - code 43 override enable, codes 44 to 47 weights 1 to 8.
// - enabled override scales speed by weight sum, capped.
// - override not applied in torque control or pulse operation.
// - each override bit has its own weight setting.
// - override disabled means 100 percent.
// - default weights 10, 20, 40, 80 percent.
// - weight sum above 150 keeps the previous multiplier.
module ssf_seq_inputs
  import ssf_pkg::*;
#(
  parameter int N_TERM = 8,
  parameter int SPD_W  = 16
)(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic [N_TERM-1:0] sequence_input_terminal,
  input  wire logic              forward_run_input,
  input  wire logic              reverse_run_input,
  input  wire logic              cmd_pulse,
  input  wire logic              cmd_pulse_dir,
  output logic                   overwrite_done,
  output logic [1:0]             ctrl_mode,
  output logic                   torque_enable,
  output logic                   torque_reverse,
  output logic                   pulse_accept,
  output logic [19:0]            cmd_position,
  output logic [SPD_W-1:0]       speed_out,
  output logic [7:0]             override_pct
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (N_TERM < 1 || N_TERM > 8)
    $error("N_TERM must be 1 to 8");
  if (SPD_W < 8 || SPD_W > 32)
    $error("SPD_W must be 8 to 32");

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [3:0]        op_mode_q;
  logic [3:0]        cm_param_q;
  logic [7:0]        func_q [N_TERM];
  logic [31:0]       wgt_q;
  logic [SPD_W-1:0]  speed_q;
  logic [SPD_W-1:0]  maxspd_q;
  logic [N_TERM-1:0] term_q;
  logic              pulse_q;
  logic              pulse_prev_q;
  logic              teach_prev_q;
  logic [19:0]       cmd_pos_q;
  logic [20:0]       entry_q [16];
  ssf_teach_t        teach_st_q;
  ssf_cmode_t        cmode_q;
  logic              trq_en_q;
  logic              trq_rev_q;
  logic              pls_acc_q;
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic [31:0]       rdata_q;
  logic [3:0]        addr_sel_q;
  logic              teach_in;
  logic              cm_sel_in;
  logic              pos_ctl_in;
  logic              trq_ctl_in;
  logic              ratio_in;
  logic              ovr_en_in;
  logic [3:0]        ovr_bits;
  logic              addr_ok;
  logic [31:0]       rd_mux;
  ssf_cmode_t        cmode_d;
  ssf_ovr_if #(.SPD_W(SPD_W)) ov ();
  // ----------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------
  // every terminal goes through one flop; edges compare to that
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      term_q       <= '0;
      pulse_q      <= 1'b0;
      pulse_prev_q <= 1'b0;
      teach_prev_q <= 1'b0;
    end
    else
    begin
      term_q       <= sequence_input_terminal;
      pulse_q      <= cmd_pulse;
      pulse_prev_q <= pulse_q;
      teach_prev_q <= teach_in;
    end
  end

  // ----------------------------------------------------------------
  // terminal function decode
  // ----------------------------------------------------------------
  // several terminals may carry one code; any active one counts
  logic [10:0] hit [N_TERM];
  for (genvar gi = 0; gi < N_TERM; gi++)
  begin : g_term
    assign hit[gi][0]  = func_q[gi] == `SSF_FN_TEACH;
    assign hit[gi][1]  = func_q[gi] == `SSF_FN_CM_SEL;
    assign hit[gi][2]  = func_q[gi] == `SSF_FN_POS_CTL;
    assign hit[gi][3]  = func_q[gi] == `SSF_FN_RATIO1;
    assign hit[gi][4]  = func_q[gi] == `SSF_FN_RATIO2;
    assign hit[gi][5]  = func_q[gi] == `SSF_FN_TRQ_CTL;
    assign hit[gi][6]  = func_q[gi] == `SSF_FN_OVR_EN;
    assign hit[gi][7]  = func_q[gi] == `SSF_FN_OVR_1;
    assign hit[gi][8]  = func_q[gi] == `SSF_FN_OVR_2;
    assign hit[gi][9]  = func_q[gi] == `SSF_FN_OVR_4;
    assign hit[gi][10] = func_q[gi] == `SSF_FN_OVR_8;
  end

  // or-reduce the per-terminal hits into function levels
  always_comb
  begin
    logic [10:0] lvl;
    lvl = '0;
    for (int i = 0; i < N_TERM; i++)
      lvl = lvl | (hit[i] & {11{term_q[i]}});
    teach_in   = lvl[0];
    cm_sel_in  = lvl[1];
    pos_ctl_in = lvl[2];
    ratio_in   = lvl[3] | lvl[4];
    trq_ctl_in = lvl[5];
    ovr_en_in  = lvl[6];
    ovr_bits   = lvl[10:7];
  end

  // ----------------------------------------------------------------
  // control mode selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (cm_param_q)
      `SSF_CMP_SPD: cmode_d = ssf_cm_spd;
      `SSF_CMP_TRQ: cmode_d = ssf_cm_trq;
      `SSF_CMP_PS:  cmode_d = cm_sel_in ? ssf_cm_spd : ssf_cm_pos;
      `SSF_CMP_PT:  cmode_d = cm_sel_in ? ssf_cm_trq : ssf_cm_pos;
      `SSF_CMP_ST:  cmode_d = cm_sel_in ? ssf_cm_trq : ssf_cm_spd;
      default:      cmode_d = ssf_cm_pos;
    endcase
    // extension mode: torque input wins over position input
    if (op_mode_q == `SSF_OPM_EXT && trq_ctl_in)
      cmode_d = ssf_cm_trq;
    else if (op_mode_q == `SSF_OPM_EXT && pos_ctl_in)
      cmode_d = ssf_cm_pos;
  end

  // registered mode, torque gating and pulse gate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmode_q   <= ssf_cm_pos;
      trq_en_q  <= 1'b0;
      trq_rev_q <= 1'b0;
      pls_acc_q <= 1'b0;
    end
    else
    begin
      cmode_q   <= cmode_d;
      // both run inputs high is ambiguous, so no torque then
      trq_en_q  <= cmode_d == ssf_cm_trq &&
                   (forward_run_input ^ reverse_run_input);
      trq_rev_q <= reverse_run_input & ~forward_run_input;
      pls_acc_q <= op_mode_q == `SSF_OPM_EXT && pos_ctl_in &&
                   !trq_ctl_in && ratio_in;
    end
  end

  // ----------------------------------------------------------------
  // commanded position
  // ----------------------------------------------------------------
  // 20-bit counter wraps once per shaft revolution
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd_pos_q <= 20'h00000;
    else if (pls_acc_q && pulse_q && !pulse_prev_q)
    begin
      if (cmd_pulse_dir)
        cmd_pos_q <= cmd_pos_q - `SSF_CNT_PER_PLS;
      else
        cmd_pos_q <= cmd_pos_q + `SSF_CNT_PER_PLS;
    end
  end

  // ----------------------------------------------------------------
  // teaching
  // ----------------------------------------------------------------
  // no stop or servo-on term: teaching works with the axis stopped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      teach_st_q <= ssf_teach_idle;
    else
      case (teach_st_q)
        ssf_teach_idle:
          if (teach_in && !teach_prev_q && op_mode_q == `SSF_OPM_POSN)
            teach_st_q <= ssf_teach_done;
        ssf_teach_done:
          if (!teach_in)
            teach_st_q <= ssf_teach_idle;
        default:
          teach_st_q <= ssf_teach_idle;
      endcase
  end

  // store at the software address select; bit 20 marks it absolute
  always_ff @(posedge hclk)
  begin
    if (teach_st_q == ssf_teach_idle && teach_in && !teach_prev_q &&
        op_mode_q == `SSF_OPM_POSN)
      entry_q[addr_sel_q] <= {1'b1, cmd_pos_q};
  end

  // ----------------------------------------------------------------
  // override hookup
  // ----------------------------------------------------------------
  assign ov.enable  = ovr_en_in && cmode_q != ssf_cm_trq &&
                      !pls_acc_q;
  assign ov.bits    = ovr_bits;
  assign ov.weight[0] = wgt_q[7:0];
  assign ov.weight[1] = wgt_q[15:8];
  assign ov.weight[2] = wgt_q[23:16];
  assign ov.weight[3] = wgt_q[31:24];
  assign ov.base    = speed_q;
  assign ov.max_spd = maxspd_q;

  ssf_override #(.SPD_W(SPD_W)) u_ovr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ov      (ov.ovr)
  );

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait states; a read is captured in its address phase, so
  // a read right behind a write to the same word sees the old value
  assign addr_ok = hsel && htrans[1] && hready;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `SSF_REG_CTRL:    rd_mux = {20'h00000, addr_sel_q, cm_param_q,
                                  op_mode_q};
      `SSF_REG_FUNC_LO,
      `SSF_REG_FUNC_HI:
        for (int i = 0; i < N_TERM; i++)
          if ((i / 4) == {31'd0, haddr[3]})
            rd_mux[(i % 4) * 8 +: 8] = func_q[i];
      `SSF_REG_OVR_WGT: rd_mux = wgt_q;
      `SSF_REG_SPEED:   rd_mux[SPD_W-1:0] = speed_q;
      `SSF_REG_MAXSPD:  rd_mux[SPD_W-1:0] = maxspd_q;
      `SSF_REG_STATUS:  rd_mux = {16'h0000, ov.mult, 1'b0, ov.enable,
                                  pls_acc_q, trq_rev_q, trq_en_q,
                                  overwrite_done, cmode_q};
      `SSF_REG_CMDPOS:  rd_mux = {12'h000, cmd_pos_q};
      `SSF_REG_SCALED:  rd_mux[SPD_W-1:0] = ov.scaled;
      default:
        if (haddr[7:6] == 2'b01)
          rd_mux = {entry_q[haddr[5:2]][20], 11'h000,
                    entry_q[haddr[5:2]][19:0]};
    endcase
  end

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_q <= haddr[7:0];
      if (addr_ok && !hwrite)
        rdata_q <= rd_mux;
    end
  end

  // data phase register writes; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_mode_q  <= 4'(`SSF_RST_CTRL);
      cm_param_q <= 4'h0;
      addr_sel_q <= 4'h0;
      wgt_q      <= `SSF_RST_OVR_WGT;
      speed_q    <= '0;
      maxspd_q   <= '1;
      for (int i = 0; i < N_TERM; i++)
        func_q[i] <= 8'h00;
    end
    else if (wr_pend_q)
      case (wr_addr_q)
        `SSF_REG_CTRL:
        begin
          op_mode_q  <= hwdata[3:0];
          cm_param_q <= hwdata[7:4];
          addr_sel_q <= hwdata[11:8];
        end
        `SSF_REG_FUNC_LO,
        `SSF_REG_FUNC_HI:
          for (int i = 0; i < N_TERM; i++)
            if ((i / 4) == {31'd0, wr_addr_q[3]})
              func_q[i] <= hwdata[(i % 4) * 8 +: 8];
        `SSF_REG_OVR_WGT: wgt_q    <= hwdata;
        `SSF_REG_SPEED:   speed_q  <= hwdata[SPD_W-1:0];
        `SSF_REG_MAXSPD:  maxspd_q <= hwdata[SPD_W-1:0];
        default:          ;
      endcase
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = rdata_q;
  assign overwrite_done = teach_st_q == ssf_teach_done;
  assign ctrl_mode      = cmode_q;
  assign torque_enable  = trq_en_q;
  assign torque_reverse = trq_rev_q;
  assign pulse_accept   = pls_acc_q;
  assign cmd_position   = cmd_pos_q;
  assign speed_out      = ov.scaled;
  assign override_pct   = ov.mult;
endmodule : ssf_seq_inputs

// ---- verification/ssf_seq_inputs_properties.sv ----
// ----------------------------------------------------------------
// port-level checks on the sequence-input block
// ----------------------------------------------------------------
module ssf_seq_inputs_checker
#(
  parameter int N_TERM = 8
)(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic [N_TERM-1:0] sequence_input_terminal,
  input wire logic              forward_run_input,
  input wire logic              reverse_run_input,
  input wire logic              overwrite_done,
  input wire logic [1:0]        ctrl_mode,
  input wire logic              torque_enable,
  input wire logic              torque_reverse,
  input wire logic              pulse_accept,
  input wire logic [19:0]       cmd_position,
  input wire logic [7:0]        override_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // 20-bit wrap makes a reverse step read as FFFF0
  property p_step;
    $changed(cmd_position) |->
      (cmd_position - $past(cmd_position)) inside {20'h00010, 20'hFFFF0};
  endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_step_src;
    $changed(cmd_position) |-> $past(pulse_accept);
  endproperty
  a_step_src: assert property (p_step_src) else $error("stray step");
  property p_trq_run;
    torque_enable |->
      $past(forward_run_input) != $past(reverse_run_input);
  endproperty
  a_trq_run: assert property (p_trq_run) else $error("torque no run");
  property p_trq_dir;
    torque_enable |-> torque_reverse == $past(reverse_run_input);
  endproperty
  a_trq_dir: assert property (p_trq_dir) else $error("torque dir");
  property p_trq_mode;
    torque_enable |-> ctrl_mode == 2'h2;
  endproperty
  a_trq_mode: assert property (p_trq_mode) else $error("torque mode");
  property p_pls_mode;
    pulse_accept |-> ctrl_mode == 2'h0;
  endproperty
  a_pls_mode: assert property (p_pls_mode) else $error("pulse mode");
  // gate needs position control and a ratio input together
  property p_pls_src;
    $rose(pulse_accept) |->
      $countones($past(sequence_input_terminal, 2)) >= 2;
  endproperty
  a_pls_src: assert property (p_pls_src) else $error("pulse gate");
  property p_ovr_cap;
    override_pct <= 8'h96;
  endproperty
  a_ovr_cap: assert property (p_ovr_cap) else $error("over 150");
  property p_teach;
    $rose(overwrite_done) |-> $past(|sequence_input_terminal, 2);
  endproperty
  a_teach: assert property (p_teach) else $error("done no teach");
endmodule : ssf_seq_inputs_checker

// ---- verification/ssf_host_model.sv ----
// ----------------------------------------------------------------
// host sequencer driving the discrete inputs
// ----------------------------------------------------------------
module ssf_host_model
#(
  parameter int N_TERM = 8
)(
  input  wire logic         hclk,
  output logic [N_TERM-1:0] sequence_input_terminal,
  output logic              forward_run_input,
  output logic              reverse_run_input,
  output logic              cmd_pulse,
  output logic              cmd_pulse_dir
);
  timeunit 1ns;
  timeprecision 1ns;
  // all lines idle low until the bench asks otherwise
  initial
  begin
    sequence_input_terminal = '0;
    forward_run_input = 1'b0;
    reverse_run_input = 1'b0;
    cmd_pulse = 1'b0;
    cmd_pulse_dir = 1'b0;
  end
  // levels change just after an edge, never on it
  task automatic set_pins(input logic [N_TERM-1:0] v);
    @(posedge hclk);
    sequence_input_terminal <= v;
  endtask : set_pins
  task automatic set_run(input logic f, input logic r);
    @(posedge hclk);
    forward_run_input <= f;
    reverse_run_input <= r;
  endtask : set_run
  // two cycles high, two low: wide enough for the input sampler
  task automatic pulse(input logic dir);
    @(posedge hclk);
    cmd_pulse_dir <= dir;
    cmd_pulse <= 1'b1;
    repeat (2) @(posedge hclk);
    cmd_pulse <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : pulse
endmodule : ssf_host_model

// ---- verification/ssf_seq_inputs_tb_top.sv ----
module ssf_seq_inputs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic        hsel;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  sequence_input_terminal;
  logic        forward_run_input;
  logic        reverse_run_input;
  logic        cmd_pulse;
  logic        cmd_pulse_dir;
  logic        overwrite_done;
  logic [1:0]  ctrl_mode;
  logic        torque_enable;
  logic        torque_reverse;
  logic        pulse_accept;
  logic [19:0] cmd_position;
  logic [15:0] speed_out;
  logic [7:0]  override_pct;
  logic [31:0] rdat;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          maxs = 65535;

  // single slave, so its ready is the bus ready
  ssf_seq_inputs DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .sequence_input_terminal, .forward_run_input,
    .reverse_run_input, .cmd_pulse, .cmd_pulse_dir, .overwrite_done,
    .ctrl_mode, .torque_enable, .torque_reverse, .pulse_accept,
    .cmd_position, .speed_out, .override_pct
  );
  ssf_host_model host (
    .hclk, .sequence_input_terminal, .forward_run_input,
    .reverse_run_input, .cmd_pulse, .cmd_pulse_dir
  );

  // ----------------------------------------------------------------
  // clock, timeout, shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // a hung handshake ends the run here
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // address phase held until ready, then data phase until ready
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : xfer
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd_chk
  // input sampler plus output flop need two edges; margin added
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask : settle
  task automatic ovr(input logic [7:0] p, input int pct);
    int spd;
    host.set_pins(p);
    repeat (5) @(posedge hclk);
    spd = 1000 * pct / 100;
    if (spd > maxs)
      spd = maxs;
    chk(override_pct, pct);
    chk(speed_out, spd);
  endtask : ovr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(override_pct, 32'h64);
    chk(hresp, 32'h0);
    rd_chk(32'h0C, 32'h5028140A);
    rd_chk(32'h14, 32'h0000FFFF);
    rd_chk(32'h30, 32'h0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_pulse;
    xfer(1'b1, 32'h0, 32'h6);
    xfer(1'b1, 32'h4, 32'h241B2523);
    host.pulse(1'b0);
    chk(cmd_position, 32'h0);
    host.set_pins(8'h02);
    settle;
    host.pulse(1'b0);
    chk(cmd_position, 32'h0);
    host.set_pins(8'h06);
    settle;
    chk(pulse_accept, 32'h1);
    host.pulse(1'b1);
    chk(cmd_position, 32'hFFFF0);
    repeat (3) host.pulse(1'b0);
    chk(cmd_position, 32'h20);
    xfer(1'b1, 32'h4, 32'h241C2523);
    settle;
    host.pulse(1'b0);
    chk(cmd_position, 32'h30);
    // teach edge outside positioning mode must do nothing
    host.set_pins(8'h07);
    settle;
    chk(overwrite_done, 32'h0);
    host.set_pins(8'h06);
    xfer(1'b1, 32'h0, 32'h507);
    host.set_pins(8'h07);
    settle;
    chk(overwrite_done, 32'h1);
    rd_chk(32'h54, 32'h80000030);
    host.set_pins(8'h06);
    settle;
    chk(overwrite_done, 32'h0);
    $display("pulse and teach test done");
  endtask : t_pulse
  task automatic t_cmode;
    logic [3:0] prm [4] = '{4'h3, 4'h4, 4'h5, 4'h0};
    logic [1:0] lo [4] = '{2'h0, 2'h0, 2'h1, 2'h0};
    logic [1:0] hi [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, 32'h0, {24'h0, prm[i], 4'h0});
      host.set_pins(8'h00);
      settle;
      chk(ctrl_mode, lo[i]);
      host.set_pins(8'h08);
      settle;
      chk(ctrl_mode, hi[i]);
    end
    $display("mode select test done");
  endtask : t_cmode
  task automatic t_torque;
    xfer(1'b1, 32'h0, 32'h6);
    xfer(1'b1, 32'h8, 32'h26);
    host.set_pins(8'h10);
    for (int i = 0; i < 4; i++)
    begin
      host.set_run(i[0], i[1]);
      settle;
      chk(ctrl_mode, 32'h2);
      chk(torque_enable, i[0] ^ i[1]);
      if (i[0] ^ i[1])
        chk(torque_reverse, i[1]);
    end
    host.set_run(1'b0, 1'b0);
    $display("torque test done");
  endtask : t_torque
  task automatic t_ovr;
    xfer(1'b1, 32'h0, 32'h10);
    xfer(1'b1, 32'h4, 32'h2E2D2C2B);
    xfer(1'b1, 32'h8, 32'h2F);
    xfer(1'b1, 32'h10, 32'h3E8);
    ovr(8'h1E, 100);
    ovr(8'h1F, 150);
    ovr(8'h0B, 50);
    ovr(8'h15, 100);
    xfer(1'b1, 32'h0C, 32'h50505096);
    ovr(8'h05, 80);
    ovr(8'h07, 80);
    ovr(8'h03, 150);
    maxs = 1200;
    xfer(1'b1, 32'h14, 32'h4B0);
    ovr(8'h03, 150);
    $display("override test done");
  endtask : t_ovr

  // reset, then the scenarios in turn
  initial
  begin
    hresetn = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsel = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_pulse;
    t_cmode;
    t_torque;
    t_ovr;
    finish_test;
  end
endmodule : ssf_seq_inputs_tb_top

bind ssf_seq_inputs ssf_seq_inputs_checker #(.N_TERM(N_TERM)) u_props (
  .hclk, .hresetn, .sequence_input_terminal, .forward_run_input,
  .reverse_run_input, .overwrite_done, .ctrl_mode, .torque_enable,
  .torque_reverse, .pulse_accept, .cmd_position, .override_pct
);
